// *** verilog/dao_defs.svh ***
`ifndef DAO_DEFS_SVH
`define DAO_DEFS_SVH

`define DAO_WORD_W 14
`define DAO_SIGN_BIT 13
`define DAO_CODE_MAX 14'h3FFF
`define DAO_CODE_MIN 14'h0000
`define DAO_FIFO_DEPTH 8
`define DAO_FIFO_PTR_W 3

`define DAO_MODE_GND 2'h0
`define DAO_MODE_THIRD 2'h1
`define DAO_MODE_TWO_THIRDS 2'h2
`define DAO_MODE_VDD 2'h3

`define DAO_CLK_PERIOD_NS 100
`define DAO_NAP_WAKE_CYCLES 100
`define DAO_SLEEP_WAKE_US 2000
`define DAO_SLEEP_WAKE_CYCLES (`DAO_SLEEP_WAKE_US * 1000 / `DAO_CLK_PERIOD_NS)
`define DAO_WAKE_CNT_W 16

`endif

// *** verilog/dao_pkg.sv ***
`include "dao_defs.svh"

package dao_pkg;

  typedef struct packed {
    logic [`DAO_WORD_W-1:0] code;
    logic overHigh;
    logic overLow;
  } dao_core_type;

  typedef struct packed {
    logic [`DAO_WORD_W-1:0] word;
    logic overflow;
  } dao_sample_type;

  typedef enum logic [1:0] {
    CH_RUN,
    CH_NAP,
    CH_SLEEP,
    CH_WAKE
  } dao_chan_state_type;

endpackage

// *** verilog/dao_output_control.sv ***
`timescale 1ns/1ps
`include "dao_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module dao_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int PTR_W = 3
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PTR_W:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != (PTR_W+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage carries no reset, so it costs no reset routing
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  fifo_never_over_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    count_q <= (PTR_W+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

////////////////////////////////////////////////////////////////////////////////
module dao_output_control #(
  parameter int SLEEP_WAKE_CYCLES = `DAO_SLEEP_WAKE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [1:0] modeLevel,
  input wire logic powerDownChanA,
  input wire logic powerDownChanB,
  input wire logic outputEnableNChanA,
  input wire logic outputEnableNChanB,
  input wire logic busSwapSelect,
  input wire dao_pkg::dao_core_type coreSampleA,
  input wire logic coreValidA,
  output logic coreReadyA,
  input wire dao_pkg::dao_core_type coreSampleB,
  input wire logic coreValidB,
  output logic coreReadyB,
  output logic [`DAO_WORD_W-1:0] firstBusWord,
  output logic overflowBusA,
  output logic firstBusOe,
  output logic [`DAO_WORD_W-1:0] secondBusWord,
  output logic overflowBusB,
  output logic secondBusOe,
  output logic twosComplement,
  output logic dcsEnable,
  output logic dataValidChanA,
  output logic dataValidChanB
);
  localparam int SAMPLE_W = $bits(dao_pkg::dao_core_type);

  function automatic dao_pkg::dao_sample_type formatSample(
    input dao_pkg::dao_core_type raw,
    input logic twos
  );
    dao_pkg::dao_sample_type s;
    s.word = raw.code;
    s.overflow = raw.overHigh || raw.overLow;
    if (raw.overHigh) begin
      s.word = `DAO_CODE_MAX;
    end else if (raw.overLow) begin
      s.word = `DAO_CODE_MIN;
    end
    if (twos) begin
      s.word[`DAO_SIGN_BIT] = ~s.word[`DAO_SIGN_BIT];
    end
    return s;
  endfunction

  function automatic logic isActive(input dao_pkg::dao_chan_state_type st);
    return (st == dao_pkg::CH_RUN) || (st == dao_pkg::CH_WAKE);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // mode decode: one pair of flags serves both channels
  logic twos_q, twos_d, dcs_q, dcs_d;

  always_comb begin
    twos_d = (modeLevel == `DAO_MODE_TWO_THIRDS) || (modeLevel == `DAO_MODE_VDD);
    dcs_d = (modeLevel == `DAO_MODE_THIRD) || (modeLevel == `DAO_MODE_TWO_THIRDS);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      twos_q <= 1'b0;
      dcs_q <= 1'b0;
    end else begin
      twos_q <= twos_d;
      dcs_q <= dcs_d;
    end
  end

  assign twosComplement = twos_q;
  assign dcsEnable = dcs_q;

  //////////////////////////////////////////////////////////////////////////////
  // per-channel input buffers; while the channel is down they take up to 8 samples, then stall the core
  logic [1:0] pd, oeN, coreValid, coreReady, fifoValid, fifoReady, pop;
  dao_pkg::dao_core_type coreIn [2];
  dao_pkg::dao_core_type fifoOut [2];

  assign pd = {powerDownChanB, powerDownChanA};
  assign oeN = {outputEnableNChanB, outputEnableNChanA};
  assign coreValid = {coreValidB, coreValidA};
  assign coreIn[0] = coreSampleA;
  assign coreIn[1] = coreSampleB;
  assign coreReadyA = coreReady[0];
  assign coreReadyB = coreReady[1];

  for (genvar g = 0; g < 2; g++) begin : gChan
    dao_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(`DAO_FIFO_DEPTH),
      .PTR_W(`DAO_FIFO_PTR_W)
    ) uFifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .inValid(coreValid[g]),
      .inReady(coreReady[g]),
      .inData(coreIn[g]),
      .outValid(fifoValid[g]),
      .outReady(fifoReady[g]),
      .outData(fifoOut[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel power state, wake timing and output word
  dao_pkg::dao_chan_state_type state_q [2];
  dao_pkg::dao_chan_state_type state_d [2];
  logic [`DAO_WAKE_CNT_W-1:0] wake_q [2];
  logic [`DAO_WAKE_CNT_W-1:0] wake_d [2];
  dao_pkg::dao_sample_type chan_q [2];
  dao_pkg::dao_sample_type chan_d [2];
  logic [1:0] drive_q, drive_d, valid_q, valid_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      state_d[i] = state_q[i];
      wake_d[i] = wake_q[i];
      case (state_q[i])
        dao_pkg::CH_RUN, dao_pkg::CH_WAKE: begin
          if (pd[i]) begin
            state_d[i] = oeN[i] ? dao_pkg::CH_SLEEP : dao_pkg::CH_NAP;
          end else if (state_q[i] == dao_pkg::CH_WAKE) begin
            if (wake_q[i] == '0) begin
              state_d[i] = dao_pkg::CH_RUN;
            end else begin
              wake_d[i] = wake_q[i] - 1'b1;
            end
          end
        end
        dao_pkg::CH_NAP: begin
          if (!pd[i]) begin
            state_d[i] = dao_pkg::CH_WAKE;
            wake_d[i] = `DAO_WAKE_CNT_W'(`DAO_NAP_WAKE_CYCLES - 1);
          end else if (oeN[i]) begin
            state_d[i] = dao_pkg::CH_SLEEP;
          end
        end
        dao_pkg::CH_SLEEP: begin
          // a sleep-to-nap move keeps the short nap recovery; the pins select the mode
          if (!pd[i]) begin
            state_d[i] = dao_pkg::CH_WAKE;
            wake_d[i] = `DAO_WAKE_CNT_W'(SLEEP_WAKE_CYCLES - 1);
          end else if (!oeN[i]) begin
            state_d[i] = dao_pkg::CH_NAP;
          end
        end
        default: begin
          state_d[i] = dao_pkg::CH_RUN;
        end
      endcase
      // converting channels keep draining even with outputs off
      fifoReady[i] = isActive(state_q[i]);
      pop[i] = fifoReady[i] && fifoValid[i];
      chan_d[i] = pop[i] ? formatSample(fifoOut[i], twos_q) : chan_q[i];
      drive_d[i] = isActive(state_d[i]) && !oeN[i];
      valid_d[i] = (state_d[i] == dao_pkg::CH_RUN);
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (!resetn) begin
        state_q[i] <= dao_pkg::CH_RUN;
        wake_q[i] <= '0;
        chan_q[i] <= '0;
        drive_q[i] <= 1'b0;
        valid_q[i] <= 1'b0;
      end else begin
        state_q[i] <= state_d[i];
        wake_q[i] <= wake_d[i];
        chan_q[i] <= chan_d[i];
        drive_q[i] <= drive_d[i];
        valid_q[i] <= valid_d[i];
      end
    end
  end

  assign dataValidChanA = valid_q[0];
  assign dataValidChanB = valid_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // bus swap: word, flag and enable of a channel always move as one
  dao_pkg::dao_sample_type first_q, first_d, second_q, second_d;
  logic firstOe_q, firstOe_d, secondOe_q, secondOe_d;

  always_comb begin
    first_d = busSwapSelect ? chan_q[0] : chan_q[1];
    second_d = busSwapSelect ? chan_q[1] : chan_q[0];
    firstOe_d = busSwapSelect ? drive_q[0] : drive_q[1];
    secondOe_d = busSwapSelect ? drive_q[1] : drive_q[0];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      first_q <= '0;
      second_q <= '0;
      firstOe_q <= 1'b0;
      secondOe_q <= 1'b0;
    end else begin
      first_q <= first_d;
      second_q <= second_d;
      firstOe_q <= firstOe_d;
      secondOe_q <= secondOe_d;
    end
  end

  assign firstBusWord = first_q.word;
  assign overflowBusA = first_q.overflow;
  assign firstBusOe = firstOe_q;
  assign secondBusWord = second_q.word;
  assign overflowBusB = second_q.overflow;
  assign secondBusOe = secondOe_q;

  //////////////////////////////////////////////////////////////////////////////
  sequence napLeaveA;
    state_q[0] == dao_pkg::CH_NAP ##1 state_q[0] == dao_pkg::CH_WAKE;
  endsequence

  sequence popOverHighA;
    pop[0] && fifoOut[0].overHigh;
  endsequence

  format_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 twosComplement == $past(modeLevel[1])) else $error("output format wrong");

  dcs_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 dcsEnable == ($past(modeLevel) == `DAO_MODE_THIRD ||
      $past(modeLevel) == `DAO_MODE_TWO_THIRDS)) else $error("stabilizer select wrong");

  clamp_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    popOverHighA |=> chan_q[0].overflow && chan_q[0].word ==
      ($past(twos_q) ? {1'b0, {(`DAO_WORD_W-1){1'b1}}} : `DAO_CODE_MAX))
    else $error("positive overrange not clamped");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    pop[1] && !fifoOut[1].overHigh && !fifoOut[1].overLow |=> !chan_q[1].overflow)
    else $error("overflow set for in-range sample");

  enable_hiz_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    outputEnableNChanA ##1 busSwapSelect |=> !firstBusOe) else $error("bus driven while off");

  sleep_enter_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    powerDownChanB && outputEnableNChanB |=> state_q[1] == dao_pkg::CH_SLEEP)
    else $error("sleep not entered");

  nap_wake_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    napLeaveA |-> wake_q[0] == `DAO_WAKE_CNT_W'(`DAO_NAP_WAKE_CYCLES - 1) && !dataValidChanA)
    else $error("nap recovery count wrong");

  lowpower_hiz_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q[0] == dao_pkg::CH_NAP || state_q[0] == dao_pkg::CH_SLEEP) |-> !drive_q[0])
    else $error("outputs driven in low power");

  run_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    state_q[0] == dao_pkg::CH_RUN && !powerDownChanA |=> state_q[0] == dao_pkg::CH_RUN)
    else $error("channel left normal operation");

  swap_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 firstBusWord == ($past(busSwapSelect) ? $past(chan_q[0].word) : $past(chan_q[1].word))
      && overflowBusA == ($past(busSwapSelect) ? $past(chan_q[0].overflow)
      : $past(chan_q[1].overflow))) else $error("bus swap mapping wrong");
endmodule

// *** test/dao_capture.sv ***
`timescale 1ns/1ps

// downstream capture: takes word and flag together, only while the bus is driven
module dao_capture (
  input wire logic clk_sys,
  input wire logic [13:0] firstBusWord,
  input wire logic overflowBusA,
  input wire logic firstBusOe,
  input wire logic [13:0] secondBusWord,
  input wire logic overflowBusB,
  input wire logic secondBusOe,
  output dao_pkg::dao_sample_type capFirst,
  output dao_pkg::dao_sample_type capSecond
);
  // no reset here: nothing is compared before the first driven word is latched
  always_ff @(posedge clk_sys) begin
    // a released bus carries nothing worth latching
    if (firstBusOe) capFirst <= {firstBusWord, overflowBusA};
    if (secondBusOe) capSecond <= {secondBusWord, overflowBusB};
  end
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  logic clk_sys, resetn, pdA, pdB, oeNA, oeNB, swap, vA, vB, rdyA, rdyB;
  logic [1:0] mode;
  dao_pkg::dao_core_type sA, sB;
  logic [13:0] w1, w2;
  logic o1, o2, oe1, oe2, twos, dcs, dvA, dvB;
  dao_pkg::dao_sample_type capFirst, capSecond;
  int mismatches, numChecks;
  dao_pkg::dao_core_type lastA, lastB;

  dao_output_control #(.SLEEP_WAKE_CYCLES(50)) u_dao_output_control (
    .clk_sys(clk_sys), .resetn(resetn), .modeLevel(mode),
    .powerDownChanA(pdA), .powerDownChanB(pdB),
    .outputEnableNChanA(oeNA), .outputEnableNChanB(oeNB), .busSwapSelect(swap),
    .coreSampleA(sA), .coreValidA(vA), .coreReadyA(rdyA),
    .coreSampleB(sB), .coreValidB(vB), .coreReadyB(rdyB),
    .firstBusWord(w1), .overflowBusA(o1), .firstBusOe(oe1),
    .secondBusWord(w2), .overflowBusB(o2), .secondBusOe(oe2),
    .twosComplement(twos), .dcsEnable(dcs),
    .dataValidChanA(dvA), .dataValidChanB(dvB));

  dao_capture u_dao_capture (
    .clk_sys(clk_sys), .firstBusWord(w1), .overflowBusA(o1), .firstBusOe(oe1),
    .secondBusWord(w2), .overflowBusB(o2), .secondBusOe(oe2),
    .capFirst(capFirst), .capSecond(capSecond));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chkS(input logic [14:0] got, input logic [14:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkB(input logic got, input logic exp);
    chkS({14'h0000, got}, {14'h0000, exp});
  endtask

  function automatic logic [14:0] expS(dao_pkg::dao_core_type s, logic tw);
    logic [13:0] w;
    w = s.overHigh ? 14'h3FFF : (s.overLow ? 14'h0000 : s.code);
    if (tw) w[13] = ~w[13];
    return {w, s.overHigh | s.overLow};
  endfunction

  function automatic dao_pkg::dao_core_type mk(int k, logic [13:0] c);
    return '{code: c, overHigh: (k == 1), overLow: (k == 2)};
  endfunction

  task automatic push(input logic a, input logic b,
                      input dao_pkg::dao_core_type x, input dao_pkg::dao_core_type y);
    @(negedge clk_sys);
    vA = a;
    vB = b;
    sA = x;
    sB = y;
  endtask

  task automatic pair(input dao_pkg::dao_core_type x, input dao_pkg::dao_core_type y);
    push(1'b1, 1'b1, x, y);
    push(1'b0, 1'b0, x, y);
    repeat (4) @(negedge clk_sys);
    lastA = x;
    lastB = y;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    numChecks = 0;
    {resetn, pdA, pdB, oeNA, oeNB, vA, vB} = '0;
    swap = 1'b1;
    mode = 2'h0;
    sA = '0;
    sB = '0;
    idle(5);
    resetn = 1'b1;
    idle(2);
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      for (int k = 0; k < 3; k++) begin
        pair(mk(k, 14'h0ABC), mk(k, 14'h2D51));
        chkS(capFirst, expS(lastA, m[1]));
        chkS(capSecond, expS(lastB, m[1]));
      end
      chkB(twos, m[1]);
      chkB(dcs, m == 1 || m == 2);
    end
    pair(mk(0, 14'h3FFE), mk(0, 14'h0001));
    chkS(capFirst, {14'h1FFE, 1'b0});
    chkB(dvA & dvB, 1'b1);
    // swapping remaps the held channel words without a new sample
    swap = 1'b0;
    idle(3);
    chkS(capFirst, expS(lastB, 1'b1));
    chkS(capSecond, expS(lastA, 1'b1));
    pair(mk(1, 14'h0100), mk(2, 14'h0200));
    chkS(capFirst, expS(lastB, 1'b1));
    chkS(capSecond, expS(lastA, 1'b1));
    // swap tied to the sample clock: the first bus carries B and A in turn
    for (int i = 0; i < 4; i++) begin
      swap = i[0];
      idle(1);
      chkS({w1, o1}, i[0] ? expS(lastA, 1'b1) : expS(lastB, 1'b1));
    end
    swap = 1'b1;
    // enable held off for a long stretch, never per sample
    oeNA = 1'b1;
    idle(4);
    chkB(oe1, 1'b0);
    chkB(oe2, 1'b1);
    oeNA = 1'b0;
    pdA = 1'b1;
    idle(4);
    chkB(oe1, 1'b0);
    chkB(dvA, 1'b0);
    chkB(dvB & oe2, 1'b1);
    for (int i = 0; i < 8; i++) push(1'b1, 1'b0, mk(0, 14'h0010 + 14'(i)), sB);
    push(1'b0, 1'b0, sA, sB);
    chkB(rdyA, 1'b0);
    chkB(rdyB, 1'b1);
    pdA = 1'b0;
    idle(50);
    chkB(dvA, 1'b0);
    chkS(capFirst, {14'h2017, 1'b0});
    idle(60);
    chkB(dvA, 1'b1);
    pdB = 1'b1;
    oeNB = 1'b1;
    idle(4);
    chkB(oe2, 1'b0);
    chkB(dvB, 1'b0);
    pdB = 1'b0;
    oeNB = 1'b0;
    idle(20);
    chkB(dvB, 1'b0);
    idle(40);
    chkB(dvB & oe2, 1'b1);
    test_done();
  end
endmodule
